// [src/srt_pkg.sv]
package srt_pkg;

  typedef logic [7:0] srt_byte_t;
  typedef logic [7:0] srt_addr_t;
  typedef logic [3:0] srt_div12_t;
  typedef logic [2:0] srt_div8_t;

  // Register addresses on the special-function-register bus
  localparam srt_addr_t SRT_ADDR_CONTROL = 8'hC8;
  localparam srt_addr_t SRT_ADDR_RELOAD_LOW = 8'hCA;
  localparam srt_addr_t SRT_ADDR_RELOAD_HIGH = 8'hCB;
  localparam srt_addr_t SRT_ADDR_COUNT_LOW = 8'hCC;
  localparam srt_addr_t SRT_ADDR_COUNT_HIGH = 8'hCD;

  // Field positions in timer_control
  localparam int SRT_BIT_HIGH_OVF = 7;
  localparam int SRT_BIT_LOW_OVF = 6;
  localparam int SRT_BIT_LOW_IRQ_EN = 5;
  localparam int SRT_BIT_CAPTURE = 4;
  localparam int SRT_BIT_SPLIT = 3;
  localparam int SRT_BIT_RUN = 2;
  localparam int SRT_BIT_EXT_SEL = 0;

  localparam srt_byte_t SRT_RESET_BYTE = 8'h00;
  localparam srt_byte_t SRT_BYTE_MAX = 8'hFF;
  localparam srt_byte_t SRT_BYTE_ONE = 8'h01;

  // Prescaler ratios
  localparam int SRT_SYS_DIV = 12;
  localparam int SRT_EXT_DIV = 8;
  localparam srt_div12_t SRT_DIV12_LAST = 4'(SRT_SYS_DIV - 1);
  localparam srt_div12_t SRT_DIV12_ZERO = 4'h0;
  localparam srt_div12_t SRT_DIV12_ONE = 4'h1;
  localparam srt_div8_t SRT_DIV8_LAST = 3'(SRT_EXT_DIV - 1);
  localparam srt_div8_t SRT_DIV8_ZERO = 3'h0;
  localparam srt_div8_t SRT_DIV8_ONE = 3'h1;

endpackage

// [src/srt_sys_div12.sv]
`timescale 1ns/1ns
module srt_sys_div12
(
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  output logic tick_out
);
  import srt_pkg::*;

  srt_div12_t count_q;
  srt_div12_t count_d;
  logic tick_q;
  logic tick_d;

  // One-cycle tick every twelfth system clock
  always_comb
  begin
    tick_d = (count_q == SRT_DIV12_LAST);
    count_d = tick_d ? SRT_DIV12_ZERO : count_q + SRT_DIV12_ONE;
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      count_q <= SRT_DIV12_ZERO;
      tick_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      tick_q <= tick_d;
    end
  end

  assign tick_out = tick_q;

endmodule

// [src/srt_ext_div8.sv]
`timescale 1ns/1ns
module srt_ext_div8
(
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic ext_osc_in,
  output logic tick_out
);
  import srt_pkg::*;

  logic meta_q;
  logic sync_q;
  logic prev_q;
  srt_div8_t count_q;
  srt_div8_t count_d;
  logic tick_q;
  logic tick_d;
  logic rise;

  // Rising edges of the synchronised oscillator, one tick per eighth edge
  always_comb
  begin
    rise = sync_q & ~prev_q;
    tick_d = rise && (count_q == SRT_DIV8_LAST);
    count_d = rise ? count_q + SRT_DIV8_ONE : count_q;
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
      count_q <= SRT_DIV8_ZERO;
      tick_q <= 1'b0;
    end
    else
    begin
      meta_q <= ext_osc_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
      count_q <= count_d;
      tick_q <= tick_d;
    end
  end

  assign tick_out = tick_q;

endmodule

// [src/srt_timer.sv]
// Behaviour
// - Split and capture off: 16-bit count, reload on full wrap, set high flag.
// - Timer interrupt enabled: every 16-bit overflow requests an interrupt via high flag.
// - 16-bit mode with low-byte enable: low eight bit wrap also interrupts.
// - Split mode: two 8-bit reload timers, each reloaded from its own byte.
// - Split mode: run control gates only the high byte; low byte always counts.
// - Byte clock: system clock if select set, else divide-by-12 or external/8.
// - External divided-by-8 tick is synchronised to the system clock first.
// - High flag sets whenever high byte wraps to zero.
// - Low flag sets whenever low byte wraps to zero, in every mode.
// - Split with low-byte enable: either byte overflow requests the interrupt.
// - Flags are never cleared by hardware; software clears them by writing.
// - Capture, not split: free 16-bit count; frame start copies count to reload.
// - Capture, split: two free 8-bit counters latched to reload on frame start.
// - Each frame-start capture requests the timer interrupt when enabled.
// - Unused control bit reads zero and ignores writes.
// - Reload registers hold reload value, or last captured byte in capture mode.
`timescale 1ns/1ns
module srt_timer
(
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire srt_pkg::srt_addr_t sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire srt_pkg::srt_byte_t sfr_wdata_in,
  output srt_pkg::srt_byte_t sfr_rdata_out,
  input wire logic timer_irq_enable_in,
  input wire logic high_byte_clock_select_in,
  input wire logic low_byte_clock_select_in,
  input wire logic ext_osc_in,
  input wire logic sof_strobe_in,
  output logic irq_out,
  output logic high_overflow_flag_out,
  output logic low_overflow_flag_out
);
  import srt_pkg::*;

  // Picks a byte's count tick from its clock-select and the external-select bit
  function automatic logic srt_pick_tick(input logic sys_sel, input logic ext_sel,
                                         input logic div12_tick, input logic ext_tick);
    logic tick;
    if (sys_sel)
    begin
      tick = 1'b1;
    end
    else if (ext_sel)
    begin
      tick = ext_tick;
    end
    else
    begin
      tick = div12_tick;
    end
    return tick;
  endfunction

  // Next value of a byte on a count step: increment, or reload / zero at the top
  function automatic srt_byte_t srt_next_byte(input srt_byte_t cur, input srt_byte_t reload,
                                              input logic to_zero);
    srt_byte_t nxt;
    if (cur == SRT_BYTE_MAX)
    begin
      nxt = to_zero ? SRT_RESET_BYTE : reload;
    end
    else
    begin
      nxt = cur + SRT_BYTE_ONE;
    end
    return nxt;
  endfunction

  // Control register fields
  logic high_overflow_flag_q;
  logic high_overflow_flag_d;
  logic low_overflow_flag_q;
  logic low_overflow_flag_d;
  logic low_byte_irq_enable_q;
  logic low_byte_irq_enable_d;
  logic frame_capture_enable_q;
  logic frame_capture_enable_d;
  logic split_mode_enable_q;
  logic split_mode_enable_d;
  logic run_control_q;
  logic run_control_d;
  logic external_clock_select_q;
  logic external_clock_select_d;

  // Data registers
  srt_byte_t reload_low_byte_q;
  srt_byte_t reload_low_byte_d;
  srt_byte_t reload_high_byte_q;
  srt_byte_t reload_high_byte_d;
  srt_byte_t count_low_byte_q;
  srt_byte_t count_low_byte_d;
  srt_byte_t count_high_byte_q;
  srt_byte_t count_high_byte_d;

  // Bus read data and interrupt request
  srt_byte_t rdata_q;
  srt_byte_t rdata_d;
  logic irq_q;
  logic irq_d;

  // Count datapath
  logic div12_tick;
  logic ext_tick;
  logic tick_low;
  logic tick_high;
  logic step_low;
  logic step_high;
  logic wrap_low;
  logic wrap_high;
  logic capture_evt;
  srt_byte_t next_low;
  srt_byte_t next_high;
  srt_byte_t control_view;

  // Write strobes per register
  logic wr_control;
  logic wr_reload_low;
  logic wr_reload_high;
  logic wr_count_low;
  logic wr_count_high;

  srt_sys_div12 u_sys_div12
  (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .tick_out(div12_tick)
  );

  srt_ext_div8 u_ext_div8
  (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .ext_osc_in(ext_osc_in),
    .tick_out(ext_tick)
  );

  // Address decode
  always_comb
  begin
    wr_control = sfr_wr_in && (sfr_addr_in == SRT_ADDR_CONTROL);
    wr_reload_low = sfr_wr_in && (sfr_addr_in == SRT_ADDR_RELOAD_LOW);
    wr_reload_high = sfr_wr_in && (sfr_addr_in == SRT_ADDR_RELOAD_HIGH);
    wr_count_low = sfr_wr_in && (sfr_addr_in == SRT_ADDR_COUNT_LOW);
    wr_count_high = sfr_wr_in && (sfr_addr_in == SRT_ADDR_COUNT_HIGH);
  end

  // Tick selection and count stepping
  always_comb
  begin
    tick_low = srt_pick_tick(low_byte_clock_select_in, external_clock_select_q,
                             div12_tick, ext_tick);
    // In 16-bit modes the high-byte select is ignored and the whole timer uses the low one
    tick_high = split_mode_enable_q ?
                srt_pick_tick(high_byte_clock_select_in, external_clock_select_q,
                              div12_tick, ext_tick) : tick_low;
    if (split_mode_enable_q)
    begin
      step_low = tick_low;
      step_high = tick_high && run_control_q;
      wrap_low = step_low && (count_low_byte_q == SRT_BYTE_MAX);
      wrap_high = step_high && (count_high_byte_q == SRT_BYTE_MAX);
      // Capture mode wraps to zero, otherwise each byte reloads from its own byte
      next_low = srt_next_byte(count_low_byte_q, reload_low_byte_q,
                               frame_capture_enable_q);
      next_high = srt_next_byte(count_high_byte_q, reload_high_byte_q,
                                frame_capture_enable_q);
    end
    else
    begin
      step_low = tick_low && run_control_q;
      wrap_low = step_low && (count_low_byte_q == SRT_BYTE_MAX);
      step_high = wrap_low;
      wrap_high = wrap_low && (count_high_byte_q == SRT_BYTE_MAX);
      // The low byte reloads only on the full 16-bit wrap, and never in capture mode
      next_low = srt_next_byte(count_low_byte_q, reload_low_byte_q,
                               frame_capture_enable_q ||
                               (count_high_byte_q != SRT_BYTE_MAX));
      next_high = srt_next_byte(count_high_byte_q, reload_high_byte_q,
                                frame_capture_enable_q);
    end
    capture_evt = frame_capture_enable_q && sof_strobe_in;
  end

  // Counter bytes: a bus write takes priority over a count step
  always_comb
  begin
    count_low_byte_d = count_low_byte_q;
    count_high_byte_d = count_high_byte_q;
    if (wr_count_low)
    begin
      count_low_byte_d = sfr_wdata_in;
    end
    else if (step_low)
    begin
      count_low_byte_d = next_low;
    end
    if (wr_count_high)
    begin
      count_high_byte_d = sfr_wdata_in;
    end
    else if (step_high)
    begin
      count_high_byte_d = next_high;
    end
  end

  // Reload bytes: a frame-start capture takes priority over a bus write
  always_comb
  begin
    reload_low_byte_d = reload_low_byte_q;
    reload_high_byte_d = reload_high_byte_q;
    if (capture_evt)
    begin
      reload_low_byte_d = count_low_byte_q;
      reload_high_byte_d = count_high_byte_q;
    end
    else
    begin
      if (wr_reload_low)
      begin
        reload_low_byte_d = sfr_wdata_in;
      end
      if (wr_reload_high)
      begin
        reload_high_byte_d = sfr_wdata_in;
      end
    end
  end

  // Control bits; flags set by hardware or by a write of one, a set in the clearing cycle wins
  always_comb
  begin
    high_overflow_flag_d = high_overflow_flag_q;
    low_overflow_flag_d = low_overflow_flag_q;
    low_byte_irq_enable_d = low_byte_irq_enable_q;
    frame_capture_enable_d = frame_capture_enable_q;
    split_mode_enable_d = split_mode_enable_q;
    run_control_d = run_control_q;
    external_clock_select_d = external_clock_select_q;
    if (wr_control)
    begin
      high_overflow_flag_d = sfr_wdata_in[SRT_BIT_HIGH_OVF];
      low_overflow_flag_d = sfr_wdata_in[SRT_BIT_LOW_OVF];
      low_byte_irq_enable_d = sfr_wdata_in[SRT_BIT_LOW_IRQ_EN];
      frame_capture_enable_d = sfr_wdata_in[SRT_BIT_CAPTURE];
      split_mode_enable_d = sfr_wdata_in[SRT_BIT_SPLIT];
      run_control_d = sfr_wdata_in[SRT_BIT_RUN];
      external_clock_select_d = sfr_wdata_in[SRT_BIT_EXT_SEL];
    end
    // Frame capture reports through the high flag so software sees a pending cause
    if (wrap_high || capture_evt)
    begin
      high_overflow_flag_d = 1'b1;
    end
    if (wrap_low)
    begin
      low_overflow_flag_d = 1'b1;
    end
  end

  // Interrupt request and read-back
  always_comb
  begin
    irq_d = timer_irq_enable_in &&
            (high_overflow_flag_q ||
             (low_byte_irq_enable_q && low_overflow_flag_q));
    control_view = SRT_RESET_BYTE;
    control_view[SRT_BIT_HIGH_OVF] = high_overflow_flag_q;
    control_view[SRT_BIT_LOW_OVF] = low_overflow_flag_q;
    control_view[SRT_BIT_LOW_IRQ_EN] = low_byte_irq_enable_q;
    control_view[SRT_BIT_CAPTURE] = frame_capture_enable_q;
    control_view[SRT_BIT_SPLIT] = split_mode_enable_q;
    control_view[SRT_BIT_RUN] = run_control_q;
    control_view[SRT_BIT_EXT_SEL] = external_clock_select_q;
    // The unused bit is never stored, so it always reads zero
    unique case (sfr_addr_in)
      SRT_ADDR_CONTROL: rdata_d = control_view;
      SRT_ADDR_RELOAD_LOW: rdata_d = reload_low_byte_q;
      SRT_ADDR_RELOAD_HIGH: rdata_d = reload_high_byte_q;
      SRT_ADDR_COUNT_LOW: rdata_d = count_low_byte_q;
      SRT_ADDR_COUNT_HIGH: rdata_d = count_high_byte_q;
      default: rdata_d = SRT_RESET_BYTE;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      high_overflow_flag_q <= 1'b0;
      low_overflow_flag_q <= 1'b0;
      low_byte_irq_enable_q <= 1'b0;
      frame_capture_enable_q <= 1'b0;
      split_mode_enable_q <= 1'b0;
      run_control_q <= 1'b0;
      external_clock_select_q <= 1'b0;
    end
    else
    begin
      high_overflow_flag_q <= high_overflow_flag_d;
      low_overflow_flag_q <= low_overflow_flag_d;
      low_byte_irq_enable_q <= low_byte_irq_enable_d;
      frame_capture_enable_q <= frame_capture_enable_d;
      split_mode_enable_q <= split_mode_enable_d;
      run_control_q <= run_control_d;
      external_clock_select_q <= external_clock_select_d;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      reload_low_byte_q <= SRT_RESET_BYTE;
      reload_high_byte_q <= SRT_RESET_BYTE;
      count_low_byte_q <= SRT_RESET_BYTE;
      count_high_byte_q <= SRT_RESET_BYTE;
    end
    else
    begin
      reload_low_byte_q <= reload_low_byte_d;
      reload_high_byte_q <= reload_high_byte_d;
      count_low_byte_q <= count_low_byte_d;
      count_high_byte_q <= count_high_byte_d;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      rdata_q <= SRT_RESET_BYTE;
      irq_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  assign sfr_rdata_out = rdata_q;
  assign irq_out = irq_q;
  assign high_overflow_flag_out = high_overflow_flag_q;
  assign low_overflow_flag_out = low_overflow_flag_q;

endmodule

// [tb/srt_timer_assertions.sv]
`timescale 1ns/1ns
module srt_timer_checker
(
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire srt_pkg::srt_addr_t sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire srt_pkg::srt_byte_t sfr_wdata_in,
  input wire srt_pkg::srt_byte_t sfr_rdata_out,
  input wire logic timer_irq_enable_in,
  input wire logic high_byte_clock_select_in,
  input wire logic low_byte_clock_select_in,
  input wire logic ext_osc_in,
  input wire logic sof_strobe_in,
  input wire logic irq_out,
  input wire logic high_overflow_flag_out,
  input wire logic low_overflow_flag_out
);
  import srt_pkg::*;
  // Shadow of low-byte irq enable (bit 1) and capture enable (bit 0)
  logic [1:0] mode_q;
  logic [1:0] mode_d;
  logic ctl_wr;
  assign ctl_wr = sfr_wr_in && (sfr_addr_in == SRT_ADDR_CONTROL);
  always_comb
  begin
    mode_d = ctl_wr ? sfr_wdata_in[5:4] : mode_q;
  end
  always_ff @(posedge mclk_in)
  begin
    mode_q <= sys_rst_in ? 2'h0 : mode_d;
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (sys_rst_in);
  property p_high_kept;
    $fell(high_overflow_flag_out) |-> $past(ctl_wr && !sfr_wdata_in[SRT_BIT_HIGH_OVF]);
  endproperty
  a_high_kept: assert property (p_high_kept) else $error("high flag dropped");
  property p_low_kept;
    $fell(low_overflow_flag_out) |-> $past(ctl_wr && !sfr_wdata_in[SRT_BIT_LOW_OVF]);
  endproperty
  a_low_kept: assert property (p_low_kept) else $error("low flag dropped");
  property p_unused_bit;
    $past(sfr_addr_in) == SRT_ADDR_CONTROL |-> sfr_rdata_out[1] == 1'b0;
  endproperty
  a_unused_bit: assert property (p_unused_bit) else $error("unused bit reads one");
  property p_irq_gate;
    irq_out |-> $past(timer_irq_enable_in);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
  property p_high_irq;
    timer_irq_enable_in && high_overflow_flag_out |=> irq_out;
  endproperty
  a_high_irq: assert property (p_high_irq) else $error("high flag gives no irq");
  property p_low_irq;
    timer_irq_enable_in && low_overflow_flag_out && mode_q[1] |=> irq_out;
  endproperty
  a_low_irq: assert property (p_low_irq) else $error("low flag gives no irq");
  property p_no_cause;
    !(timer_irq_enable_in && (high_overflow_flag_out || (mode_q[1] && low_overflow_flag_out)))
      |=> !irq_out;
  endproperty
  a_no_cause: assert property (p_no_cause) else $error("irq without cause");
  property p_cap_flag;
    sof_strobe_in && mode_q[0] |=> high_overflow_flag_out;
  endproperty
  a_cap_flag: assert property (p_cap_flag) else $error("capture sets no flag");
  property p_cap_irq;
    sof_strobe_in && mode_q[0] && timer_irq_enable_in ##1 timer_irq_enable_in |=> irq_out;
  endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("capture gives no irq");
  property p_reload_rb;
    // A capture in the write cycle beats the write, so it must be absent there
    sfr_wr_in && sfr_addr_in == SRT_ADDR_RELOAD_LOW && !(sof_strobe_in && mode_q[0])
      ##1 sfr_addr_in == SRT_ADDR_RELOAD_LOW && !sfr_wr_in
      |=> sfr_rdata_out == $past(sfr_wdata_in, 2);
  endproperty
  a_reload_rb: assert property (p_reload_rb) else $error("reload readback wrong");
  c_capture: cover property (sof_strobe_in && mode_q[0]);
  c_high_irq: cover property ($rose(high_overflow_flag_out) ##1 irq_out);
  c_low_irq: cover property (low_overflow_flag_out && mode_q[1] ##1 irq_out);
endmodule
bind srt_timer srt_timer_checker srt_timer_checker_i (.mclk_in, .sys_rst_in, .sfr_addr_in,
  .sfr_wr_in, .sfr_wdata_in, .sfr_rdata_out, .timer_irq_enable_in, .high_byte_clock_select_in,
  .low_byte_clock_select_in, .ext_osc_in, .sof_strobe_in, .irq_out, .high_overflow_flag_out,
  .low_overflow_flag_out);

// [tb/srt_far_side.sv]
`timescale 1ns/1ns
module srt_far_side
(
  input wire logic mclk_in,
  output logic sof_strobe_out,
  output logic ext_osc_out
);
  initial
  begin
    sof_strobe_out = 1'b0;
    ext_osc_out = 1'b0;
  end
  task automatic send_sof();
    @(negedge mclk_in);
    sof_strobe_out = 1'b1;
    @(negedge mclk_in);
    sof_strobe_out = 1'b0;
  endtask
  // Oscillator bursts; the pin idles low between them
  task automatic osc_pulses(input int n, input int half);
    repeat (n)
    begin
      repeat (half) @(negedge mclk_in);
      ext_osc_out = 1'b1;
      repeat (half) @(negedge mclk_in);
      ext_osc_out = 1'b0;
    end
  endtask
endmodule

// [tb/test_srt_timer.sv]
`timescale 1ns/1ns
module test_srt_timer;
  import srt_pkg::*;
  logic clk, rst, wr, ien, hsel, lsel, irq, hf, lf, sof, osc;
  srt_addr_t addr;
  srt_byte_t wdata, rdata;
  int n_mismatch = 0;
  int samples_checked = 0;
  srt_addr_t regs [7] = '{8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hCE};
  srt_timer srt_timer_i (.mclk_in(clk), .sys_rst_in(rst), .sfr_addr_in(addr),
    .sfr_wr_in(wr), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .timer_irq_enable_in(ien),
    .high_byte_clock_select_in(hsel), .low_byte_clock_select_in(lsel), .ext_osc_in(osc),
    .sof_strobe_in(sof), .irq_out(irq), .high_overflow_flag_out(hf),
    .low_overflow_flag_out(lf));
  srt_far_side srt_far_side_i (.mclk_in(clk), .sof_strobe_out(sof), .ext_osc_out(osc));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic give_verdict();
    $display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp_byte(input srt_byte_t got, input srt_byte_t exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Interrupt settles two edges after its cause
  task automatic cmp_irq(input logic exp);
    repeat (2) @(negedge clk);
    cmp_byte({7'h0, irq}, {7'h0, exp});
  endtask
  task automatic cmp_flags(input logic exp_h, input logic exp_l);
    cmp_byte({6'h00, hf, lf}, {6'h00, exp_h, exp_l});
  endtask
  task automatic wr_reg(input srt_addr_t a, input srt_byte_t d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input srt_addr_t a, input srt_byte_t exp);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    cmp_byte(rdata, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
  initial
  begin
    {rst, wr, ien, hsel, lsel, addr, wdata} = {5'h11, 8'h00, 8'h00};
    idle(16);
    rst = 1'b0;
    foreach (regs[i]) rd_reg(regs[i], 8'h00);
    wr_reg(SRT_ADDR_CONTROL, 8'h02);
    rd_reg(SRT_ADDR_CONTROL, 8'h00);
    wr_reg(SRT_ADDR_RELOAD_LOW, 8'h34);
    wr_reg(SRT_ADDR_RELOAD_HIGH, 8'h12);
    wr_reg(SRT_ADDR_COUNT_LOW, 8'hFF);
    wr_reg(SRT_ADDR_COUNT_HIGH, 8'hFF);
    ien = 1'b1;
    wr_reg(SRT_ADDR_CONTROL, 8'h04);
    idle(4);
    rd_reg(SRT_ADDR_CONTROL, 8'hC4);
    cmp_flags(1'b1, 1'b1);
    rd_reg(SRT_ADDR_COUNT_HIGH, 8'h12);
    srt_far_side_i.send_sof();
    rd_reg(SRT_ADDR_RELOAD_LOW, 8'h34);
    rd_reg(SRT_ADDR_RELOAD_HIGH, 8'h12);
    cmp_irq(1'b1);
    wr_reg(SRT_ADDR_CONTROL, 8'h04);
    rd_reg(SRT_ADDR_CONTROL, 8'h04);
    cmp_irq(1'b0);
    wr_reg(SRT_ADDR_CONTROL, 8'h00);
    wr_reg(SRT_ADDR_COUNT_LOW, 8'hFF);
    wr_reg(SRT_ADDR_COUNT_HIGH, 8'h00);
    wr_reg(SRT_ADDR_CONTROL, 8'h24);
    idle(4);
    rd_reg(SRT_ADDR_CONTROL, 8'h64);
    cmp_irq(1'b1);
    wr_reg(SRT_ADDR_CONTROL, 8'h20);
    rd_reg(SRT_ADDR_CONTROL, 8'h20);
    wr_reg(SRT_ADDR_CONTROL, 8'h40);
    cmp_irq(1'b0);
    lsel = 1'b0;
    hsel = 1'b1;
    // Divide-by-12 clock: 24 count edges give exactly two steps
    wr_reg(SRT_ADDR_COUNT_LOW, 8'h00);
    wr_reg(SRT_ADDR_COUNT_HIGH, 8'h00);
    wr_reg(SRT_ADDR_CONTROL, 8'h04);
    idle(23);
    rd_reg(SRT_ADDR_COUNT_LOW, 8'h02);
    rd_reg(SRT_ADDR_COUNT_HIGH, 8'h00);
    wr_reg(SRT_ADDR_CONTROL, 8'h40);
    wr_reg(SRT_ADDR_RELOAD_LOW, 8'h80);
    wr_reg(SRT_ADDR_RELOAD_HIGH, 8'h90);
    wr_reg(SRT_ADDR_COUNT_LOW, 8'hFF);
    wr_reg(SRT_ADDR_COUNT_HIGH, 8'hFF);
    wr_reg(SRT_ADDR_CONTROL, 8'h09);
    srt_far_side_i.osc_pulses(8, 2);
    idle(8);
    rd_reg(SRT_ADDR_COUNT_LOW, 8'h80);
    rd_reg(SRT_ADDR_COUNT_HIGH, 8'hFF);
    rd_reg(SRT_ADDR_CONTROL, 8'h49);
    hsel = 1'b0;
    wr_reg(SRT_ADDR_CONTROL, 8'h0D);
    srt_far_side_i.osc_pulses(7, 5);
    idle(8);
    rd_reg(SRT_ADDR_COUNT_LOW, 8'h80);
    srt_far_side_i.osc_pulses(1, 5);
    idle(8);
    rd_reg(SRT_ADDR_COUNT_LOW, 8'h81);
    rd_reg(SRT_ADDR_COUNT_HIGH, 8'h90);
    rd_reg(SRT_ADDR_CONTROL, 8'h8D);
    cmp_flags(1'b1, 1'b0);
    cmp_irq(1'b1);
    wr_reg(SRT_ADDR_CONTROL, 8'h6D);
    cmp_irq(1'b1);
    wr_reg(SRT_ADDR_CONTROL, 8'h00);
    wr_reg(SRT_ADDR_COUNT_LOW, 8'hCD);
    wr_reg(SRT_ADDR_COUNT_HIGH, 8'hAB);
    wr_reg(SRT_ADDR_CONTROL, 8'h15);
    srt_far_side_i.send_sof();
    rd_reg(SRT_ADDR_RELOAD_LOW, 8'hCD);
    rd_reg(SRT_ADDR_RELOAD_HIGH, 8'hAB);
    rd_reg(SRT_ADDR_CONTROL, 8'h95);
    cmp_flags(1'b1, 1'b0);
    cmp_irq(1'b1);
    wr_reg(SRT_ADDR_COUNT_LOW, 8'hFF);
    wr_reg(SRT_ADDR_COUNT_HIGH, 8'hFF);
    wr_reg(SRT_ADDR_CONTROL, 8'h15);
    srt_far_side_i.osc_pulses(8, 2);
    idle(8);
    rd_reg(SRT_ADDR_COUNT_LOW, 8'h00);
    rd_reg(SRT_ADDR_COUNT_HIGH, 8'h00);
    rd_reg(SRT_ADDR_CONTROL, 8'hD5);
    wr_reg(SRT_ADDR_COUNT_HIGH, 8'hFF);
    wr_reg(SRT_ADDR_CONTROL, 8'h1D);
    srt_far_side_i.osc_pulses(8, 3);
    idle(8);
    srt_far_side_i.send_sof();
    rd_reg(SRT_ADDR_RELOAD_LOW, 8'h01);
    rd_reg(SRT_ADDR_RELOAD_HIGH, 8'h00);
    give_verdict();
  end
endmodule
